// File: hw/ncnu_core.sv
// Top of the conversion and negate unit with register port and interrupt
//
// Overview of operation
// [RQ1] Widen sign-extends the 16-bit operand to a 32-bit result.
// [RQ2] Widen, integer-to-real and both inverts give an enable-out equal to enable.
// [RQ3] Those four set binary-result, status, logic-result, first-check, clear or, keep the rest.
// [RQ4] Integer-to-BCD turns the 32-bit operand into signed seven-digit BCD up to 9999999.
// [RQ5] An unrepresentable BCD result drives enable-out low.
// [RQ6] Integer-to-BCD updates binary-result, overflow, stored-overflow, status, logic-result.
// [RQ7] With enable low nothing converts and enable-out is low.
// [RQ8] Integer-to-real converts the 32-bit signed operand to a real.
// [RQ9] Word invert xors the operand with an all-ones 16-bit mask.
// [RQ10] Double-word invert xors the operand with an all-ones 32-bit mask.
// [RQ11] Both twos-complement operations return the arithmetic negation.
// [RQ12] Negates follow enable on enable-out, except low on overflow while enabled.
// [RQ13] Twos-complement updates binary-result, both codes, overflow, stored-overflow, more.
// [RQ14] Real negate flips only the sign bit.
// [RQ15] Each BCD digit sits in its own nibble as its binary code.
// [RQ16] Reals are 32-bit single-precision floating point.
// [RQ17] Negating the most negative value of a width is an overflow.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ncnu_core
#(
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned DATA_W = 32
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   output logic irq,
   output logic enable_out_flag,
   output logic [31:0] result_out,
   output logic [ncnu_pkg::SW_W-1:0] status_word_out
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   ncnu_conv_if conv ();

   logic ctrl_en_q;
   ncnu_pkg::ncnu_op_t ctrl_op_q;
   logic exec_q;
   logic [31:0] operand_q;
   logic [31:0] result_q;
   logic [ncnu_pkg::SW_W-1:0] sw_q;
   logic eno_q;
   logic [ncnu_pkg::IRQ_W-1:0] irq_status_q;
   logic [ncnu_pkg::IRQ_W-1:0] irq_mask_q;
   logic [DATA_W-1:0] rdata_q;

   logic wr_ctrl;
   logic wr_operand;
   logic wr_sw;
   logic wr_irq_status;
   logic wr_irq_mask;

   logic [31:0] result_d;
   logic result_we;
   logic eno_d;
   logic [ncnu_pkg::SW_W-1:0] sw_d;
   logic ovf;
   logic [31:0] neg_res;
   logic [ncnu_pkg::IRQ_W-1:0] irq_set;
   logic [DATA_W-1:0] rdata_d;

   // ----------------------------------------
   // Converters
   // ----------------------------------------
   assign conv.operand = operand_q;

   ncnu_bcd_conv u_bcd
   (
      .conv (conv.bcd_side)
   );

   ncnu_int_to_real u_real
   (
      .conv (conv.real_side)
   );

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   assign wr_ctrl = reg_wr && (reg_addr == ncnu_pkg::ADDR_CTRL);
   assign wr_operand = reg_wr && (reg_addr == ncnu_pkg::ADDR_OPERAND);
   assign wr_sw = reg_wr && (reg_addr == ncnu_pkg::ADDR_STATUS_WORD);
   assign wr_irq_status = reg_wr && (reg_addr == ncnu_pkg::ADDR_IRQ_STATUS);
   assign wr_irq_mask = reg_wr && (reg_addr == ncnu_pkg::ADDR_IRQ_MASK);

   // ----------------------------------------
   // Command register; a write launches one operation
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         ctrl_en_q <= 1'b0;
         ctrl_op_q <= ncnu_pkg::widen_int_op;
      end
      else if (wr_ctrl)
      begin
         ctrl_en_q <= reg_wdata[ncnu_pkg::CTRL_EN_POS];
         ctrl_op_q <= ncnu_pkg::ncnu_op_t'(reg_wdata[ncnu_pkg::CTRL_OP_LSB +: ncnu_pkg::OP_W]);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         exec_q <= 1'b0;
      end
      else
      begin
         exec_q <= wr_ctrl;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         operand_q <= ncnu_pkg::DATA_RESET;
      end
      else if (wr_operand)
      begin
         operand_q <= reg_wdata[31:0];
      end
   end

   // ----------------------------------------
   // Operation datapath
   // ----------------------------------------
   always_comb
   begin
      ovf = 1'b0;
      neg_res = 32'h0000_0000;
      result_d = result_q;
      result_we = 1'b0;
      eno_d = 1'b0; // [RQ7]
      sw_d = sw_q;
      if (ctrl_en_q)
      begin
         sw_d[ncnu_pkg::SW_OR] = 1'b0;
         sw_d[ncnu_pkg::SW_FIRST_CHECK] = 1'b1;
         sw_d[ncnu_pkg::SW_STATUS] = 1'b1;
         case (ctrl_op_q)
            ncnu_pkg::widen_int_op:
            begin
               result_d = {{16{operand_q[15]}}, operand_q[15:0]}; // [RQ1]
               result_we = 1'b1;
            end
            ncnu_pkg::dint_to_decimal_op:
            begin
               ovf = conv.bcd_overflow; // [RQ4]
               result_d = conv.bcd_result;
               result_we = !ovf;
            end
            ncnu_pkg::dint_to_real_op:
            begin
               result_d = conv.real_result; // [RQ8]
               result_we = 1'b1;
            end
            ncnu_pkg::invert_word_op:
            begin
               result_d = {16'h0000, operand_q[15:0] ^ ncnu_pkg::WORD_MASK}; // [RQ9]
               result_we = 1'b1;
            end
            ncnu_pkg::invert_dword_op:
            begin
               result_d = operand_q ^ ncnu_pkg::DWORD_MASK; // [RQ10]
               result_we = 1'b1;
            end
            ncnu_pkg::negate_word_op:
            begin
               ovf = (operand_q[15:0] == ncnu_pkg::WORD_MIN); // [RQ17]
               neg_res = {{16{1'b0}}, 16'h0000 - operand_q[15:0]}; // [RQ11]
               result_d = neg_res;
               result_we = 1'b1;
            end
            ncnu_pkg::negate_dword_op:
            begin
               ovf = (operand_q == ncnu_pkg::DWORD_MIN); // [RQ17]
               neg_res = 32'h0000_0000 - operand_q; // [RQ11]
               result_d = neg_res;
               result_we = 1'b1;
            end
            ncnu_pkg::negate_real_op:
            begin
               // NaN input is the only case taken as a real overflow
               ovf = (operand_q[30:23] == ncnu_pkg::REAL_EXP_ALL) && (|operand_q[22:0]);
               result_d = operand_q;
               result_d[ncnu_pkg::REAL_SIGN_POS] = ~operand_q[ncnu_pkg::REAL_SIGN_POS]; // [RQ14]
               result_we = 1'b1;
            end
            default:
            begin
               result_we = 1'b0;
            end
         endcase
         eno_d = !ovf; // [RQ2] [RQ5] [RQ12]
         sw_d[ncnu_pkg::SW_BINARY_RESULT] = !ovf; // [RQ3] [RQ6] [RQ13]
         sw_d[ncnu_pkg::SW_LOGIC_RESULT] = !ovf; // [RQ3] [RQ6] [RQ13]
         case (ctrl_op_q)
            ncnu_pkg::dint_to_decimal_op:
            begin
               sw_d[ncnu_pkg::SW_OVERFLOW] = ovf; // [RQ6]
               sw_d[ncnu_pkg::SW_STORED_OVF] = sw_q[ncnu_pkg::SW_STORED_OVF] | ovf;
            end
            ncnu_pkg::negate_word_op, ncnu_pkg::negate_dword_op:
            begin
               sw_d[ncnu_pkg::SW_OVERFLOW] = ovf; // [RQ13]
               sw_d[ncnu_pkg::SW_STORED_OVF] = sw_q[ncnu_pkg::SW_STORED_OVF] | ovf;
               // Codes: 10 positive or overflow, 01 negative, 00 zero
               if (ctrl_op_q == ncnu_pkg::negate_word_op)
               begin
                  sw_d[ncnu_pkg::SW_COND_HI] = ovf || (!neg_res[15] && |neg_res[15:0]);
                  sw_d[ncnu_pkg::SW_COND_LO] = !ovf && neg_res[15];
               end
               else
               begin
                  sw_d[ncnu_pkg::SW_COND_HI] = ovf || (!neg_res[31] && |neg_res);
                  sw_d[ncnu_pkg::SW_COND_LO] = !ovf && neg_res[31];
               end
            end
            default:
            begin
               sw_d[ncnu_pkg::SW_OVERFLOW] = sw_q[ncnu_pkg::SW_OVERFLOW]; // [RQ3]
            end
         endcase
      end
   end

   // ----------------------------------------
   // Result, enable-out and status word
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         result_q <= ncnu_pkg::DATA_RESET;
      end
      else if (exec_q && result_we)
      begin
         result_q <= result_d;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         eno_q <= 1'b0;
      end
      else if (exec_q)
      begin
         eno_q <= eno_d; // [RQ7]
      end
   end

   // An operation outranks a same-cycle software write
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         sw_q <= ncnu_pkg::SW_RESET;
      end
      else if (exec_q)
      begin
         sw_q <= sw_d;
      end
      else if (wr_sw)
      begin
         sw_q <= reg_wdata[ncnu_pkg::SW_W-1:0];
      end
   end

   assign result_out = result_q;
   assign enable_out_flag = eno_q;
   assign status_word_out = sw_q;

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   assign irq_set[ncnu_pkg::IRQ_DONE_POS] = exec_q;
   assign irq_set[ncnu_pkg::IRQ_FAULT_POS] = exec_q && ctrl_en_q && !eno_d;

   // Set wins over a same-cycle write-one clear
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         irq_status_q <= ncnu_pkg::IRQ_RESET;
      end
      else
      begin
         irq_status_q <= (irq_status_q & ~(wr_irq_status ? reg_wdata[ncnu_pkg::IRQ_W-1:0]
                                                         : ncnu_pkg::IRQ_RESET)) | irq_set;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         irq_mask_q <= ncnu_pkg::IRQ_RESET;
      end
      else if (wr_irq_mask)
      begin
         irq_mask_q <= reg_wdata[ncnu_pkg::IRQ_W-1:0];
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // ----------------------------------------
   // Read port, data valid only in the cycle after the strobe
   // ----------------------------------------
   always_comb
   begin
      rdata_d = '0;
      case (reg_addr)
         ncnu_pkg::ADDR_CTRL:
         begin
            rdata_d[ncnu_pkg::CTRL_EN_POS] = ctrl_en_q;
            rdata_d[ncnu_pkg::CTRL_OP_LSB +: ncnu_pkg::OP_W] = ctrl_op_q;
         end
         ncnu_pkg::ADDR_OPERAND:
         begin
            rdata_d[31:0] = operand_q;
         end
         ncnu_pkg::ADDR_RESULT:
         begin
            rdata_d[31:0] = result_q;
         end
         ncnu_pkg::ADDR_STATUS_WORD:
         begin
            rdata_d[ncnu_pkg::SW_W-1:0] = sw_q;
         end
         ncnu_pkg::ADDR_IRQ_STATUS:
         begin
            rdata_d[ncnu_pkg::IRQ_W-1:0] = irq_status_q;
         end
         ncnu_pkg::ADDR_IRQ_MASK:
         begin
            rdata_d[ncnu_pkg::IRQ_W-1:0] = irq_mask_q;
         end
         default:
         begin
            rdata_d = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rdata_q <= '0;
      end
      else
      begin
         rdata_q <= reg_rd ? rdata_d : '0;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : ncnu_core
`default_nettype wire

// File: common/ncnu_pkg.sv
// Shared constants and types of the conversion and negate unit
package ncnu_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_OPERAND = 8'h04;
   localparam logic [7:0] ADDR_RESULT = 8'h08;
   localparam logic [7:0] ADDR_STATUS_WORD = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int unsigned CTRL_EN_POS = 0;
   localparam int unsigned CTRL_OP_LSB = 4;
   localparam int unsigned OP_W = 3;

   // ----------------------------------------
   // Processor status word bit positions
   // ----------------------------------------
   localparam int unsigned SW_W = 9;
   localparam int unsigned SW_FIRST_CHECK = 0;
   localparam int unsigned SW_LOGIC_RESULT = 1;
   localparam int unsigned SW_STATUS = 2;
   localparam int unsigned SW_OR = 3;
   localparam int unsigned SW_STORED_OVF = 4;
   localparam int unsigned SW_OVERFLOW = 5;
   localparam int unsigned SW_COND_LO = 6;
   localparam int unsigned SW_COND_HI = 7;
   localparam int unsigned SW_BINARY_RESULT = 8;
   localparam logic [8:0] SW_RESET = 9'h000;

   // ----------------------------------------
   // Interrupt bits and reset values
   // ----------------------------------------
   localparam int unsigned IRQ_W = 2;
   localparam int unsigned IRQ_DONE_POS = 0;
   localparam int unsigned IRQ_FAULT_POS = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;

   // ----------------------------------------
   // Datapath constants
   // ----------------------------------------
   localparam logic [15:0] WORD_MASK = 16'hffff;
   localparam logic [31:0] DWORD_MASK = 32'hffff_ffff;
   localparam logic [15:0] WORD_MIN = 16'h8000;
   localparam logic [31:0] DWORD_MIN = 32'h8000_0000;
   localparam int unsigned BCD_DIGITS = 7;
   localparam int unsigned BCD_BIN_W = 24;
   localparam logic [31:0] BCD_MAX = 32'h0098_967f;
   localparam logic [3:0] BCD_SIGN_POS = 4'h0;
   localparam logic [3:0] BCD_SIGN_NEG = 4'hf;
   localparam int unsigned REAL_SIGN_POS = 31;
   localparam logic [7:0] REAL_EXP_BIAS = 8'h7f;
   localparam logic [7:0] REAL_EXP_ALL = 8'hff;

   typedef enum logic [2:0] {
      widen_int_op,
      dint_to_decimal_op,
      dint_to_real_op,
      invert_word_op,
      invert_dword_op,
      negate_word_op,
      negate_dword_op,
      negate_real_op
   } ncnu_op_t;

endpackage : ncnu_pkg

// File: common/ncnu_conv_if.sv
// Operand and results shared between the core and its converters
`timescale 1ns/1ps
`default_nettype none
interface ncnu_conv_if;
   logic [31:0] operand;
   logic [31:0] bcd_result;
   logic bcd_overflow;
   logic [31:0] real_result;

   modport core_side (output operand, input bcd_result, input bcd_overflow, input real_result);
   modport bcd_side (input operand, output bcd_result, output bcd_overflow);
   modport real_side (input operand, output real_result);
endinterface : ncnu_conv_if
`default_nettype wire

// File: hw/ncnu_bcd_conv.sv
// Signed 32-bit integer to seven-digit signed BCD converter
`timescale 1ns/1ps
`default_nettype none
module ncnu_bcd_conv
(
   ncnu_conv_if.bcd_side conv
);
   logic [31:0] mag;
   logic [4*ncnu_pkg::BCD_DIGITS-1:0] bcd;

   // Shift-and-add-three over the low magnitude bits
   always_comb
   begin
      mag = conv.operand[31] ? (~conv.operand + 32'h0000_0001) : conv.operand;
      bcd = '0;
      for (int i = ncnu_pkg::BCD_BIN_W - 1; i >= 0; i--)
      begin
         for (int j = 0; j < ncnu_pkg::BCD_DIGITS; j++)
         begin
            if (bcd[4*j +: 4] > 4'h4)
            begin
               bcd[4*j +: 4] = bcd[4*j +: 4] + 4'h3; // [RQ15]
            end
         end
         bcd = {bcd[4*ncnu_pkg::BCD_DIGITS-2:0], mag[i]};
      end
   end

   assign conv.bcd_overflow = (mag > ncnu_pkg::BCD_MAX); // [RQ4]
   assign conv.bcd_result = {conv.operand[31] ? ncnu_pkg::BCD_SIGN_NEG : ncnu_pkg::BCD_SIGN_POS,
                             bcd}; // [RQ4]

endmodule : ncnu_bcd_conv
`default_nettype wire

// File: hw/ncnu_int_to_real.sv
// Signed 32-bit integer to single-precision real, round to nearest even
`timescale 1ns/1ps
`default_nettype none
module ncnu_int_to_real
(
   ncnu_conv_if.real_side conv
);
   logic [31:0] mag;
   logic [4:0] msb;
   logic [31:0] norm;
   logic round_up;
   logic [24:0] sum;
   logic [7:0] expo;
   logic [22:0] frac;

   always_comb
   begin
      mag = conv.operand[31] ? (~conv.operand + 32'h0000_0001) : conv.operand;
      msb = 5'h00;
      for (int i = 0; i < 32; i++)
      begin
         if (mag[i])
         begin
            msb = 5'(i);
         end
      end
      norm = mag << (5'h1f - msb);
      round_up = norm[7] & ((|norm[6:0]) | norm[8]);
      sum = {2'b01, norm[30:8]} + {24'h000000, round_up};
      frac = sum[24] ? 23'h000000 : sum[22:0];
      expo = {3'h0, msb} + ncnu_pkg::REAL_EXP_BIAS + {7'h00, sum[24]};
   end

   // Zero has no leading one and maps to positive zero
   assign conv.real_result = (mag == 32'h0000_0000) ? 32'h0000_0000
                             : {conv.operand[31], expo, frac}; // [RQ8] [RQ16]

endmodule : ncnu_int_to_real
`default_nettype wire

// File: testbench/ncnu_core_monitor.sv
// Concurrent checks on the ports of the conversion and negate unit
`timescale 1ns/1ps
`default_nettype none
module ncnu_core_monitor
#(
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned DATA_W = 32
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic irq,
   input wire logic enable_out_flag,
   input wire logic [31:0] result_out,
   input wire logic [ncnu_pkg::SW_W-1:0] status_word_out
);
   // ----------
   // Operation tracking
   // ----------
   logic [31:0] opnd_q;
   logic ctl;
   logic go;
   logic [2:0] op;
   logic plain;
   assign ctl = reg_wr && reg_addr == ADDR_W'(ncnu_pkg::ADDR_CTRL);
   assign go = ctl && reg_wdata[0];
   assign op = reg_wdata[6:4];
   assign plain = op == 3'h0 || op == 3'h2 || op == 3'h3 || op == 3'h4;
   always_ff @(posedge core_clk)
   begin
      if (reset)
         opnd_q <= 32'h0000_0000;
      else if (reg_wr && reg_addr == ADDR_W'(ncnu_pkg::ADDR_OPERAND))
         opnd_q <= reg_wdata[31:0];
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // ----------
   // Properties
   // ----------
   property p_widen;
      go && op == 3'h0 |-> ##3 result_out == {{16{opnd_q[15]}}, opnd_q[15:0]};
   endproperty
   a_widen: assert property (p_widen)
      else $error("widen result wrong");
   property p_eno_follow;
      go && plain |-> ##3 enable_out_flag;
   endproperty
   a_eno_follow: assert property (p_eno_follow)
      else $error("enable-out not following enable");
   property p_flags;
      go && plain |-> ##3 status_word_out[8] && status_word_out[3:0] == 4'h7
         && status_word_out[7:4] == $past(status_word_out[7:4], 2);
   endproperty
   a_flags: assert property (p_flags)
      else $error("status bits wrong after plain op");
   property p_bcd_ovf;
      go && op == 3'h1 && ($signed(opnd_q) > 9999999 || $signed(opnd_q) < -9999999)
         |-> ##3 !enable_out_flag && status_word_out[5];
   endproperty
   a_bcd_ovf: assert property (p_bcd_ovf)
      else $error("decimal overflow not flagged");
   property p_eno_off;
      ctl && !reg_wdata[0] |-> ##3 !enable_out_flag && result_out == $past(result_out, 2)
         && status_word_out == $past(status_word_out, 2);
   endproperty
   a_eno_off: assert property (p_eno_off)
      else $error("disabled op changed outputs");
   property p_inv_word;
      go && op == 3'h3 |-> ##3 result_out == {16'h0000, opnd_q[15:0] ^ 16'hffff};
   endproperty
   a_inv_word: assert property (p_inv_word)
      else $error("word invert wrong");
   property p_inv_dword;
      go && op == 3'h4 |-> ##3 result_out == (opnd_q ^ 32'hffff_ffff);
   endproperty
   a_inv_dword: assert property (p_inv_dword)
      else $error("double word invert wrong");
   property p_neg_word;
      go && op == 3'h5 |-> ##3 result_out[15:0] == 16'h0000 - opnd_q[15:0]
         && enable_out_flag == (opnd_q[15:0] != 16'h8000);
   endproperty
   a_neg_word: assert property (p_neg_word)
      else $error("word negate wrong");
   property p_neg_dword;
      go && op == 3'h6 |-> ##3 result_out == 32'h0000_0000 - opnd_q
         && enable_out_flag == (opnd_q != 32'h8000_0000)
         && status_word_out[5] == (opnd_q == 32'h8000_0000);
   endproperty
   a_neg_dword: assert property (p_neg_dword)
      else $error("double word negate wrong");
   property p_neg_real;
      go && op == 3'h7 |-> ##3 result_out == (opnd_q ^ 32'h8000_0000);
   endproperty
   a_neg_real: assert property (p_neg_real)
      else $error("real negate wrong");
endmodule : ncnu_core_monitor
bind ncnu_core ncnu_core_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon
(
   .core_clk(core_clk),
   .reset(reset),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .irq(irq),
   .enable_out_flag(enable_out_flag),
   .result_out(result_out),
   .status_word_out(status_word_out)
);
`default_nettype wire

// File: testbench/ncnu_seq_model.sv
// Sequencer model that drives the unit's register port
`timescale 1ns/1ps
`default_nettype none
module ncnu_seq_model
(
   input wire logic core_clk,
   output var logic [7:0] reg_addr,
   output var logic [31:0] reg_wdata,
   output var logic reg_wr,
   output var logic reg_rd
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // ----------
   // Bus cycles, each followed by one idle cycle
   // ----------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask : rd
endmodule : ncnu_seq_model
`default_nettype wire

// File: testbench/test_numeric_convert_negate_unit.sv
// Self-checking bench of the conversion and negate unit
`timescale 1ns/1ps
`default_nettype none
module test_numeric_convert_negate_unit;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   wire [7:0] reg_addr;
   wire [31:0] reg_wdata;
   wire reg_wr;
   wire reg_rd;
   logic [31:0] reg_rdata;
   logic irq;
   logic enable_out_flag;
   logic [31:0] result_out;
   logic [ncnu_pkg::SW_W-1:0] status_word_out;
   logic [31:0] exp_q[$];
   logic [31:0] res_m = 32'h0000_0000;
   logic rd_d = 1'b0;
   int fail_count = 0;
   int n_checks = 0;
   logic [31:0] edge_v[14] = '{32'h0000_0000, 32'h0000_8000, 32'h8000_0000, 32'h0098_967f,
      32'h0098_9680, 32'hff67_6981, 32'hff67_6980, 32'h7fc0_0001, 32'h7f80_0000,
      32'h0000_7fff, 32'h1234_ffff, 32'h0100_0001, 32'h0100_0003, 32'h7fff_ffff};
   always #5 core_clk = ~core_clk;
   ncnu_seq_model seq (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   ncnu_core dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .enable_out_flag(enable_out_flag), .result_out(result_out),
      .status_word_out(status_word_out));
   // ----------
   // Helpers
   // ----------
   task automatic tally_and_finish();
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      seq.rd(a);
   endtask : rd_chk
   function automatic logic [31:0] to_bcd(input longint a);
      logic [31:0] b;
      longint m;
      b = a < 0 ? 32'hf000_0000 : 32'h0000_0000;
      m = a < 0 ? -a : a;
      for (int i = 0; i < 7; i++)
      begin
         b[4 * i +: 4] = 4'(m % 10);
         m = m / 10;
      end
      return b;
   endfunction : to_bcd
   task automatic do_op(input logic [2:0] op, input logic en, input logic [31:0] v);
      logic [8:0] s;
      logic [1:0] m;
      logic ovf;
      logic neg;
      logic zero;
      longint a;
      logic [63:0] d;
      logic [23:0] r;
      s = 9'($urandom);
      m = 2'($urandom);
      ovf = 1'b0;
      a = longint'($signed(v));
      seq.wr(ncnu_pkg::ADDR_STATUS_WORD, {23'h0, s});
      seq.wr(ncnu_pkg::ADDR_IRQ_MASK, {30'h0, m});
      seq.wr(ncnu_pkg::ADDR_OPERAND, v);
      seq.wr(ncnu_pkg::ADDR_CTRL, {25'h0, op, 3'h0, en});
      if (en)
      begin
         case (op)
            3'h0: res_m = {{16{v[15]}}, v[15:0]};
            3'h1: ovf = a > 9999999 || a < -9999999;
            3'h2:
            begin
               // Exact double, then round to nearest even single
               d = $realtobits(real'(a));
               r = {1'b0, d[51:29]} + 24'(d[28] & (d[29] | (|d[27:0])));
               res_m = {d[63], 8'(d[62:52] - 11'h380 + 11'(r[23])), r[22:0]};
               if (a == 0)
                  res_m = 32'h0000_0000;
            end
            3'h3: res_m = {16'h0000, v[15:0] ^ 16'hffff};
            3'h4: res_m = v ^ 32'hffff_ffff;
            3'h5: ovf = v[15:0] == 16'h8000;
            3'h6: ovf = v == 32'h8000_0000;
            default: ovf = v[30:23] == 8'hff && v[22:0] != 23'h0;
         endcase
         if (op == 3'h1 && !ovf)
            res_m = to_bcd(a);
         if (op == 3'h5)
            res_m = {16'h0000, 16'h0000 - v[15:0]};
         if (op == 3'h6)
            res_m = 32'h0000_0000 - v;
         if (op == 3'h7)
            res_m = v ^ 32'h8000_0000;
         neg = op == 3'h5 ? res_m[15] : res_m[31];
         zero = op == 3'h5 ? res_m[15:0] == 16'h0000 : res_m == 32'h0000_0000;
         s[8] = !ovf;
         s[3:0] = {2'b01, !ovf, 1'b1};
         if (op == 3'h1 || op == 3'h5 || op == 3'h6)
            s[5:4] = {ovf, s[4] | ovf};
         if (op == 3'h5 || op == 3'h6)
            s[7:6] = ovf || !(neg || zero) ? 2'b10 : {1'b0, neg};
      end
      @(posedge core_clk);
      rd_chk(ncnu_pkg::ADDR_RESULT, res_m);
      rd_chk(ncnu_pkg::ADDR_STATUS_WORD, {23'h0, s});
      rd_chk(ncnu_pkg::ADDR_IRQ_STATUS, {30'h0, ovf, 1'b1});
      rd_chk(ncnu_pkg::ADDR_CTRL, {25'h0, op, 3'h0, en});
      #1;
      check({31'h0, enable_out_flag}, {31'h0, en & !ovf});
      check(result_out, res_m);
      check({23'h0, status_word_out}, {23'h0, s});
      check({31'h0, irq}, {31'h0, |(m & {ovf, 1'b1})});
      @(posedge core_clk);
      seq.wr(ncnu_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
   endtask : do_op
   // ----------
   // Read-data watcher and test sequence
   // ----------
   always @(posedge core_clk)
      rd_d <= reg_rd;
   always @(negedge core_clk)
      if (rd_d)
         check(reg_rdata, exp_q.pop_front());
   initial
   begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      tally_and_finish();
   end
   initial
   begin
      void'($urandom(80));
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      seq.wr(ncnu_pkg::ADDR_RESULT, $urandom);
      seq.wr(8'h18, $urandom);
      for (int i = 0; i < 7; i++)
         rd_chk(8'(4 * i), 32'h0000_0000);
      for (int k = 0; k < 8; k++)
      begin
         foreach (edge_v[i])
            do_op(3'(k), 1'b1, edge_v[i]);
         repeat (6) do_op(3'(k), 1'b1, $urandom);
         do_op(3'(k), 1'b0, $urandom);
      end
      tally_and_finish();
   end
endmodule : test_numeric_convert_negate_unit
`default_nettype wire
